// ### inc/ushc_pkg.sv
// Purpose: Constants for the UART shadow control register bank.
// Assumes: AXI4-Lite, 32-bit data, byte addresses as printed.
// Notes:   Control bits sit in the low bits of each word.
// Behaviour
// - Read-only 16-bit field shows receive FIFO entry count, zero at reset.
// - Writing one to tx flush bit empties the transmit FIFO control.
// - Writing one to rx flush bit empties the receive FIFO control.
// - Both flush bits clear themselves after acting.
// - Whole reset bit asserts controller reset at once, releases on clock.
// - Whole reset covers every clock domain of the controller.
// - Shadow RTS and break share storage with modem and line control bits.
// - Without auto flow, RTS bit high drives active-low RTS output low.
// - Auto flow with FIFOs on also gates RTS off above rx threshold.
// - Loopback holds RTS pin high, RTS bit loops to modem input.
// - Break bit forces serial output to spacing level, logic 0.
// - Outside loopback serial line stays low while break bit is set.
// - Infrared mode with break pulses active-low infrared output.
// - In loopback a break is looped to own receiver, not the line.
// - Rx threshold picked by two-bit trigger: one, quarter, half, full-2.
package ushc_pkg;
    // ==========================================================
    // Register map
    localparam logic [31:0] RX_FILL_COUNT_ADDR   = 32'h5000_1084;
    localparam logic [31:0] SW_RESET_CTRL_ADDR   = 32'h5000_1088;
    localparam logic [31:0] SHADOW_RTS_ADDR      = 32'h5000_108c;
    localparam logic [31:0] SHADOW_BREAK_ADDR    = 32'h5000_1090;
    localparam logic [31:0] MODEM_CONTROL_ADDR   = 32'h5000_10c0;
    localparam logic [31:0] LINE_CONTROL_ADDR    = 32'h5000_10c4;
    localparam logic [31:0] FIFO_CONTROL_ADDR    = 32'h5000_10c8;
    localparam int          FIELD_W              = 16;
    // ==========================================================
    // Field positions
    localparam int RST_TX_FLUSH    = 2;
    localparam int RST_RX_FLUSH    = 1;
    localparam int RST_WHOLE       = 0;
    localparam int SHADOW_BIT      = 0;
    localparam int MODEM_RTS       = 1;
    localparam int MODEM_LOOP      = 4;
    localparam int MODEM_AUTO_FLOW = 5;
    localparam int MODEM_SIR       = 6;
    localparam int LINE_BREAK      = 6;
    localparam int FIFO_ENABLE     = 0;
    localparam int FIFO_TRIG_LO    = 6;
    localparam int FIFO_TRIG_HI    = 7;
    // ==========================================================
    // Trigger codes, responses, reset values
    localparam logic [1:0]  TRIG_ONE     = 2'h0;
    localparam logic [1:0]  TRIG_QUARTER = 2'h1;
    localparam logic [1:0]  TRIG_HALF    = 2'h2;
    localparam logic [1:0]  TRIG_FULL_M2 = 2'h3;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam logic [31:0] RD_ZERO      = 32'h0000_0000;
endpackage

// ### verilog/ushc_reset_sync.sv
// Purpose: Reset stretcher, asserts at once and releases on the clock.
// Assumes: arst_req is a glitch-free level from a flip-flop.
// Notes:   Output is the controller reset for every domain.
`timescale 1ns/1ps
module ushc_reset_sync #(
    parameter int STAGES = 2              // Release delay in clocks
) (
    input  wire logic aclk,               // Clock
    input  wire logic arst_req,           // Reset request, high active
    output logic      rst_out_n           // Controller reset, low active
);
    logic [STAGES-1:0] chain_reg;

    // ==========================================================
    // Chain: asserts without the clock, shifts ones in to release
    always_ff @(posedge aclk or posedge arst_req) begin
        if (arst_req) begin
            chain_reg <= '0;
        end else begin
            chain_reg <= {chain_reg[STAGES-2:0], 1'b1};
        end
    end

    assign rst_out_n = chain_reg[STAGES-1];
endmodule

// ### verilog/ushc_regs.sv
// Purpose: UART shadow control registers, FIFO levels, RTS and break.
// Assumes: Push and pop strobes come from logic on aclk.
// Notes:   Framing engine, baud generator and FIFO RAMs live elsewhere.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ushc_regs
    import ushc_pkg::*;
#(
    parameter int DEPTH    = 16,          // FIFO depth in entries
    parameter int SIR_HALF = 8            // Half period of break pulses
) (
    input  wire logic        aclk,        // Clock, 100 MHz
    input  wire logic        aresetn,     // Sync reset, low active
    input  wire logic [31:0] awaddr,      // Write address
    input  wire logic        awvalid,     // Write address valid
    output logic             awready,     // Write address ready
    input  wire logic [31:0] wdata,       // Write data
    input  wire logic [3:0]  wstrb,       // Write byte strobes
    input  wire logic        wvalid,      // Write data valid
    output logic             wready,      // Write data ready
    output logic [1:0]       bresp,       // Write response
    output logic             bvalid,      // Write response valid
    input  wire logic        bready,      // Write response ready
    input  wire logic [31:0] araddr,      // Read address
    input  wire logic        arvalid,     // Read address valid
    output logic             arready,     // Read address ready
    output logic [31:0]      rdata,       // Read data
    output logic [1:0]       rresp,       // Read response
    output logic             rvalid,      // Read data valid
    input  wire logic        rready,      // Read data ready
    input  wire logic        rx_push,     // Receiver stored a character
    input  wire logic        rx_pop,      // Software took a character
    input  wire logic        tx_push,     // Software queued a character
    input  wire logic        tx_pop,      // Transmitter took a character
    input  wire logic        tx_serial,   // Serial data from transmitter
    input  wire logic        sin,         // Serial input pin
    output logic             sout,        // Serial output pin
    output logic             rts_n,       // Request to send, low active
    output logic             sir_out_n,   // Infrared output, low active
    output logic             rx_serial,   // Serial data to receiver
    output logic             loop_cts,    // Looped RTS to modem input
    output logic             tx_queue_flush, // Tx FIFO flush pulse
    output logic             rx_queue_flush, // Rx FIFO flush pulse
    output logic             core_rst_n,  // Controller reset, low active
    output logic [15:0]      rx_level,    // Rx FIFO entries
    output logic [15:0]      tx_level     // Tx FIFO entries
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int SW = $clog2(SIR_HALF + 1);

    // ==========================================================
    // Byte-strobe merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // Next count of a FIFO occupancy counter
    function automatic logic [CW-1:0] step(input logic [CW-1:0] cnt,
                                           input logic push,
                                           input logic pop,
                                           input logic flush);
        logic [CW-1:0] res;
        res = cnt;
        if (flush) begin
            res = '0;
        end else if (push && cnt != CW'(DEPTH) && !(pop && cnt != '0)) begin
            res = cnt + CW'(1);
        end else if (pop && cnt != '0 && !push) begin
            res = cnt - CW'(1);
        end
        return res;
    endfunction

    // ==========================================================
    // State
    logic          aw_full_reg, aw_full_next;
    logic [31:0]   aw_addr_reg, aw_addr_next;
    logic          w_full_reg, w_full_next;
    logic [31:0]   w_data_reg, w_data_next;
    logic [3:0]    w_strb_reg, w_strb_next;
    logic          bvalid_reg, bvalid_next;
    logic [1:0]    bresp_reg, bresp_next;
    logic          rvalid_reg, rvalid_next;
    logic [31:0]   rdata_reg, rdata_next;
    logic [1:0]    rresp_reg, rresp_next;
    logic          rts_bit_reg, rts_bit_next;
    logic          brk_reg, brk_next;
    logic          loop_reg, loop_next;
    logic          afce_reg, afce_next;
    logic          sir_reg, sir_next;
    logic          fen_reg, fen_next;
    logic [1:0]    trig_reg, trig_next;
    logic          txf_reg, txf_next;
    logic          rxf_reg, rxf_next;
    logic          whole_reg, whole_next;
    logic [CW-1:0] rx_cnt_reg, rx_cnt_next;
    logic [CW-1:0] tx_cnt_reg, tx_cnt_next;
    logic [2:0]    sin_s_reg, sin_s_next;
    logic          sin_reg, sin_next;
    logic [SW-1:0] sir_cnt_reg, sir_cnt_next;
    logic          sir_ph_reg, sir_ph_next;
    logic          sout_reg, sout_next;
    logic          rts_n_reg, rts_n_next;
    logic          sir_n_reg, sir_n_next;
    logic          rx_ser_reg, rx_ser_next;
    logic          do_write;
    logic [31:0]   wword;
    logic [CW-1:0] thresh;

    // ==========================================================
    // Bus handshakes; write commits once address and data are both held
    assign awready  = !aw_full_reg;
    assign wready   = !w_full_reg;
    assign arready  = !rvalid_reg;
    assign bvalid   = bvalid_reg;
    assign bresp    = bresp_reg;
    assign rvalid   = rvalid_reg;
    assign rdata    = rdata_reg;
    assign rresp    = rresp_reg;
    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wword    = merge(RD_ZERO, w_data_reg, w_strb_reg);

    // ==========================================================
    // Write channel next state
    always_comb begin
        aw_full_next = aw_full_reg;
        aw_addr_next = aw_addr_reg;
        w_full_next  = w_full_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        if (awvalid && !aw_full_reg) begin
            aw_full_next = 1'b1;
            aw_addr_next = awaddr;
        end
        if (wvalid && !w_full_reg) begin
            w_full_next = 1'b1;
            w_data_next = wdata;
            w_strb_next = wstrb;
        end
        if (do_write) begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            case (aw_addr_reg)
                RX_FILL_COUNT_ADDR, SW_RESET_CTRL_ADDR, SHADOW_RTS_ADDR,
                SHADOW_BREAK_ADDR, MODEM_CONTROL_ADDR, LINE_CONTROL_ADDR,
                FIFO_CONTROL_ADDR: bresp_next = RESP_OKAY;
                default:           bresp_next = RESP_SLVERR;
            endcase
        end else if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
    end

    // ==========================================================
    // Control bits; shadow and full registers write one shared copy
    always_comb begin
        rts_bit_next = rts_bit_reg;
        brk_next     = brk_reg;
        loop_next    = loop_reg;
        afce_next    = afce_reg;
        sir_next     = sir_reg;
        fen_next     = fen_reg;
        trig_next    = trig_reg;
        txf_next     = 1'b0;
        rxf_next     = 1'b0;
        whole_next   = 1'b0;
        if (do_write) begin
            case (aw_addr_reg)
                SW_RESET_CTRL_ADDR: begin
                    txf_next   = wword[RST_TX_FLUSH];
                    rxf_next   = wword[RST_RX_FLUSH];
                    whole_next = wword[RST_WHOLE];
                end
                SHADOW_RTS_ADDR: begin
                    if (w_strb_reg[0]) begin
                        rts_bit_next = wword[SHADOW_BIT];
                    end
                end
                SHADOW_BREAK_ADDR: begin
                    if (w_strb_reg[0]) begin
                        brk_next = wword[SHADOW_BIT];
                    end
                end
                MODEM_CONTROL_ADDR: begin
                    if (w_strb_reg[0]) begin
                        rts_bit_next = wword[MODEM_RTS];
                        loop_next    = wword[MODEM_LOOP];
                        afce_next    = wword[MODEM_AUTO_FLOW];
                        sir_next     = wword[MODEM_SIR];
                    end
                end
                LINE_CONTROL_ADDR: begin
                    if (w_strb_reg[0]) begin
                        brk_next = wword[LINE_BREAK];
                    end
                end
                FIFO_CONTROL_ADDR: begin
                    if (w_strb_reg[0]) begin
                        fen_next  = wword[FIFO_ENABLE];
                        trig_next = wword[FIFO_TRIG_HI:FIFO_TRIG_LO];
                        // Turning FIFOs off empties both of them
                        if (fen_reg && !wword[FIFO_ENABLE]) begin
                            txf_next = 1'b1;
                            rxf_next = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Read channel; read data registered when the address is taken
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = RD_ZERO;
            case (araddr)
                RX_FILL_COUNT_ADDR: rdata_next[FIELD_W-1:0] = rx_level;
                SW_RESET_CTRL_ADDR: rdata_next = RD_ZERO;
                SHADOW_RTS_ADDR:    rdata_next[SHADOW_BIT] = rts_bit_reg;
                SHADOW_BREAK_ADDR:  rdata_next[SHADOW_BIT] = brk_reg;
                MODEM_CONTROL_ADDR: begin
                    rdata_next[MODEM_RTS]       = rts_bit_reg;
                    rdata_next[MODEM_LOOP]      = loop_reg;
                    rdata_next[MODEM_AUTO_FLOW] = afce_reg;
                    rdata_next[MODEM_SIR]       = sir_reg;
                end
                LINE_CONTROL_ADDR:  rdata_next[LINE_BREAK] = brk_reg;
                FIFO_CONTROL_ADDR: begin
                    rdata_next[FIFO_ENABLE]               = fen_reg;
                    rdata_next[FIFO_TRIG_HI:FIFO_TRIG_LO] = trig_reg;
                end
                default:            rresp_next = RESP_SLVERR;
            endcase
        end else if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
    end

    // ==========================================================
    // Bus and control registers, reset by the bus reset only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= RD_ZERO;
            w_full_reg  <= 1'b0;
            w_data_reg  <= RD_ZERO;
            w_strb_reg  <= '0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= RD_ZERO;
            rresp_reg   <= RESP_OKAY;
            rts_bit_reg <= 1'b0;
            brk_reg     <= 1'b0;
            loop_reg    <= 1'b0;
            afce_reg    <= 1'b0;
            sir_reg     <= 1'b0;
            fen_reg     <= 1'b0;
            trig_reg    <= TRIG_ONE;
            txf_reg     <= 1'b0;
            rxf_reg     <= 1'b0;
            whole_reg   <= 1'b0;
        end else begin
            aw_full_reg <= aw_full_next;
            aw_addr_reg <= aw_addr_next;
            w_full_reg  <= w_full_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            rts_bit_reg <= rts_bit_next;
            brk_reg     <= brk_next;
            loop_reg    <= loop_next;
            afce_reg    <= afce_next;
            sir_reg     <= sir_next;
            fen_reg     <= fen_next;
            trig_reg    <= trig_next;
            txf_reg     <= txf_next;
            rxf_reg     <= rxf_next;
            whole_reg   <= whole_next;
        end
    end

    // ==========================================================
    // Controller reset; the one output serves every controller domain
    ushc_reset_sync #(
        .STAGES    (2)
    ) u_rst (
        .aclk      (aclk),
        .arst_req  (whole_reg || !aresetn),
        .rst_out_n (core_rst_n)
    );

    assign tx_queue_flush = txf_reg;
    assign rx_queue_flush = rxf_reg;
    assign rx_level       = FIELD_W'(rx_cnt_reg);
    assign tx_level       = FIELD_W'(tx_cnt_reg);

    // ==========================================================
    // Rx threshold from the trigger code
    always_comb begin
        case (trig_reg)
            TRIG_ONE:     thresh = CW'(1);
            TRIG_QUARTER: thresh = CW'(DEPTH / 4);
            TRIG_HALF:    thresh = CW'(DEPTH / 2);
            TRIG_FULL_M2: thresh = CW'(DEPTH - 2);
            default:      thresh = CW'(1);
        endcase
    end

    // ==========================================================
    // Line side next values; flush beats a push in the same cycle
    always_comb begin
        rx_cnt_next  = step(rx_cnt_reg, rx_push, rx_pop, rxf_reg);
        tx_cnt_next  = step(tx_cnt_reg, tx_push, tx_pop, txf_reg);
        sin_s_next   = {sin_s_reg[1:0], sin};
        sin_next     = (sin_s_reg[1] == sin_s_reg[2]) ? sin_s_reg[2] : sin_reg;
        sir_cnt_next = sir_cnt_reg;
        sir_ph_next  = 1'b0;
        // Break in infrared mode: free-running low pulses
        if (sir_reg && brk_reg && !loop_reg) begin
            if (sir_cnt_reg == SW'(SIR_HALF - 1)) begin
                sir_cnt_next = '0;
                sir_ph_next  = !sir_ph_reg;
            end else begin
                sir_cnt_next = sir_cnt_reg + SW'(1);
                sir_ph_next  = sir_ph_reg;
            end
        end else begin
            sir_cnt_next = '0;
        end
        sir_n_next = !sir_ph_next;
        if (loop_reg) begin
            sout_next   = 1'b1;
            rts_n_next  = 1'b1;
            rx_ser_next = tx_serial && !brk_reg;
        end else begin
            sout_next   = tx_serial && !brk_reg;
            rts_n_next  = !rts_bit_reg;
            rx_ser_next = sin_reg;
            if (afce_reg && fen_reg && rx_cnt_reg > thresh) begin
                rts_n_next = 1'b1;
            end
        end
    end

    // ==========================================================
    // Line side registers, held in reset by the controller reset
    always_ff @(posedge aclk) begin
        if (!core_rst_n) begin
            rx_cnt_reg  <= '0;
            tx_cnt_reg  <= '0;
            sin_s_reg   <= '1;
            sin_reg     <= 1'b1;
            sir_cnt_reg <= '0;
            sir_ph_reg  <= 1'b0;
            sout_reg    <= 1'b1;
            rts_n_reg   <= 1'b1;
            sir_n_reg   <= 1'b1;
            rx_ser_reg  <= 1'b1;
        end else begin
            rx_cnt_reg  <= rx_cnt_next;
            tx_cnt_reg  <= tx_cnt_next;
            sin_s_reg   <= sin_s_next;
            sin_reg     <= sin_next;
            sir_cnt_reg <= sir_cnt_next;
            sir_ph_reg  <= sir_ph_next;
            sout_reg    <= sout_next;
            rts_n_reg   <= rts_n_next;
            sir_n_reg   <= sir_n_next;
            rx_ser_reg  <= rx_ser_next;
        end
    end

    // Pins come straight from flip-flops; loop_cts is the AND of two of them
    assign sout      = sout_reg;
    assign rts_n     = rts_n_reg;
    assign sir_out_n = sir_n_reg;
    assign rx_serial = rx_ser_reg;
    assign loop_cts  = loop_reg && rts_bit_reg;
endmodule

// ### verif/ushc_modem.sv
// Purpose: Modem on the serial side of the shadow control registers.
// Assumes: Shares aclk; the line idles at mark.
// Notes:   Sends only while request to send is active.
`timescale 1ns/1ps
module ushc_modem (
    input  wire logic       aclk,    // Clock
    input  wire logic       rts_n,   // Request to send, low active
    input  wire logic       sout,    // Line from device
    output logic            sin = 1'b1,      // Line to device
    output logic [7:0]      low_run = 8'h00  // Cycles sout stayed low
);
    // =================================================
    // Line model: mark when held off, else a changing pattern
    always @(posedge aclk) begin
        sin <= rts_n ? 1'b1 : ~sin;
        low_run <= sout ? 8'h00 : low_run + 8'(low_run != 8'hff);
    end
endmodule

// ### verif/ushc_checker.sv
// Purpose: Port assertions for the shadow control registers.
// Assumes: One clock domain, bus reset disables all checks.
// Notes:   Line rules are seen through sout, sir and loop outputs.
`timescale 1ns/1ps
module ushc_checker #(
    parameter int DEPTH = 16                // FIFO depth
) (
    input wire logic        aclk,           // Clock
    input wire logic        aresetn,        // Bus reset
    input wire logic        bvalid,         // Write response
    input wire logic        bready,         // Response taken
    input wire logic [1:0]  bresp,          // Response code
    input wire logic        rx_push,        // Rx store
    input wire logic        rx_pop,         // Rx take
    input wire logic        rx_queue_flush, // Rx flush
    input wire logic        tx_queue_flush, // Tx flush
    input wire logic [15:0] rx_level,       // Rx count
    input wire logic [15:0] tx_level,       // Tx count
    input wire logic        tx_serial,      // Tx data
    input wire logic        sout,           // Line out
    input wire logic        rx_serial,      // Rx data
    input wire logic        sir_out_n,      // Infrared out
    input wire logic        loop_cts,       // Looped RTS
    input wire logic        rts_n,          // RTS pin
    input wire logic        core_rst_n      // Core reset
);
    // =================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bresp_holds: assert property (bvalid && !bready |=>
        bvalid && $stable(bresp)) else $error("write response dropped early");
    a_rx_flush_clear: assert property (rx_queue_flush |=>
        !rx_queue_flush && rx_level == 16'h0000) else $error("rx flush");
    a_tx_flush_clear: assert property (tx_queue_flush |=>
        !tx_queue_flush && tx_level == 16'h0000) else $error("tx flush");
    a_rx_push_count: assert property (rx_push && !rx_pop && core_rst_n &&
        !rx_queue_flush && rx_level < DEPTH |=> !core_rst_n ||
        rx_level == $past(rx_level) + 16'h0001) else $error("rx count");
    a_serial_route: assert property (!tx_serial && core_rst_n |=>
        !core_rst_n || !sout || !rx_serial) else $error("serial route");
    a_sir_with_break: assert property (!sir_out_n |-> !sout)
        else $error("infrared pulse without break");
    a_loop_rts_high: assert property (loop_cts |=> rts_n)
        else $error("rts pin active in loopback");
    a_core_release: assert property ($rose(core_rst_n) |->
        $past(aresetn)) else $error("core reset released early");
endmodule
bind ushc_regs ushc_checker #(.DEPTH(DEPTH)) chk_i (.*);

// ### verif/testbench.sv
// Purpose: Self-checking bench for the shadow control registers.
// Assumes: AXI4-Lite master tasks sample on the falling edge.
// Notes:   Infrared half period cut to 2 so pulses come quickly.
`timescale 1ns/1ps
module testbench;
    import ushc_pkg::*;
    localparam int SH = 2;  // Infrared half period
    localparam int D = 16;  // FIFO depth
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 1;
    logic arvalid = 0, rready = 1, rx_push = 0, tx_push = 0, lv;
    logic tx_serial = 1, rx_pop = 0, tx_pop = 0, awready, wready, bvalid;
    logic arready, rvalid, sin, sout, rts_n, sir_out_n, rx_serial, loop_cts;
    logic tx_queue_flush, rx_queue_flush, core_rst_n;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp;
    logic [15:0] rx_level, tx_level;
    logic [7:0]  low_run;
    int          err_count = 0, samples_checked = 0, rst_cnt = 0, tg = 0;
    ushc_regs #(.DEPTH(D), .SIR_HALF(SH)) uut (.*);
    ushc_modem mdm (.*);
    // =================================================
    // Clock, random transmit data, core reset monitor
    always #5 aclk = ~aclk;
    always @(posedge aclk) tx_serial <= 1'($urandom);
    always @(negedge aclk) if (aresetn && !core_rst_n) rst_cnt++;
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus tasks start and end just after a rising edge
    task automatic wr(input logic [31:0] a, d, input logic [1:0] er = 0);
        logic ta, tw, dn = 0;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
        while (!dn) begin
            @(negedge aclk);
            ta = awready && awvalid; tw = wready && wvalid; dn = bvalid;
            if (dn) chk(bresp, er);
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
        end
    endtask
    task automatic rc(input logic [31:0] a, e, input logic [1:0] er = 0);
        logic ta, dn = 0;
        araddr <= a; arvalid <= 1;
        while (!dn) begin
            @(negedge aclk);
            ta = arready && arvalid; dn = rvalid;
            if (dn) chk({rresp, rdata}, {er, e});
            @(posedge aclk);
            if (ta) arvalid <= 0;
        end
    endtask
    task automatic wt(input int n); repeat (n) @(posedge aclk); endtask
    task automatic push(input int n);
        repeat (n) begin rx_push <= 1; tx_push <= 1; @(posedge aclk); end
        rx_push <= 0; tx_push <= 0;
    endtask
    function automatic int thr_of(input int c);
        return c == 0 ? 1 : c == 1 ? D / 4 : c == 2 ? D / 2 : D - 2;
    endfunction
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog, far beyond the expected run
    initial begin wt(5000); err_count++; end_of_test; end
    initial begin
        int n;
        void'($urandom(72));
        wt(16);
        aresetn <= 1;
        rc(RX_FILL_COUNT_ADDR, 0);
        rc(SW_RESET_CTRL_ADDR, 0);
        chk(rts_n, 1);
        n = $urandom_range(15, 2);
        push(n); wt(2);
        rc(RX_FILL_COUNT_ADDR, n);
        rx_pop <= 1; wt(1); rx_pop <= 0; rc(RX_FILL_COUNT_ADDR, n - 1);
        wr(SW_RESET_CTRL_ADDR, 32'h0000_0006); wt(2);
        chk({rx_level, tx_level}, 0);
        rc(SW_RESET_CTRL_ADDR, 0);
        $display("test fill and flush done");
        wr(SHADOW_RTS_ADDR, 32'hffff_ffff);
        rc(SHADOW_RTS_ADDR, 1);
        rc(MODEM_CONTROL_ADDR, 32'h0000_0002);
        chk(rts_n, 0);
        wr(MODEM_CONTROL_ADDR, 0); wt(2);
        rc(SHADOW_RTS_ADDR, 0);
        chk(rts_n, 1);
        wr(MODEM_CONTROL_ADDR, 32'h0000_0022);
        for (int c = 0; c < 4; c++) begin
            wr(FIFO_CONTROL_ADDR, {24'h0000_00, 2'(c), 6'h01});
            wr(SW_RESET_CTRL_ADDR, 32'h0000_0002);
            push(thr_of(c)); wt(3);
            chk(rts_n, 0);
            push(1); wt(3);
            chk(rts_n, 1);
        end
        $display("test rts control done");
        wr(MODEM_CONTROL_ADDR, 32'h0000_0012); wt(2);
        chk({rts_n, loop_cts}, 3);
        wr(SHADOW_BREAK_ADDR, 1); wt(2);
        chk({sout, rx_serial}, 2);
        rc(LINE_CONTROL_ADDR, 32'h0000_0040);
        wr(MODEM_CONTROL_ADDR, 0); wt(22);
        chk({sout, sir_out_n, low_run >= 8'h14}, 3);
        wr(MODEM_CONTROL_ADDR, 32'h0000_0040);
        @(negedge aclk) lv = sir_out_n;
        repeat (12) begin
            @(negedge aclk) tg += (sir_out_n != lv);
            lv = sir_out_n;
        end
        @(posedge aclk);
        chk(tg >= 12 / SH - 1, 1);
        $display("test break done");
        wr(SW_RESET_CTRL_ADDR, 1); wt(4);
        chk({rst_cnt > 2, core_rst_n}, 3);
        chk({rx_level, tx_level}, 0);
        wr(32'h5000_1000, 1, RESP_SLVERR);
        rc(32'h5000_1000, RD_ZERO, RESP_SLVERR);
        $display("test reset and unmapped done");
        end_of_test;
    end
endmodule
